// ### necr_pkg.sv
package necr_pkg;
    localparam int NECR_SECTORS = 5;
    localparam int NECR_SECTOR_BYTES = 256;
    localparam int NECR_ADDR_W = 8;
    localparam logic [7:0] NECR_OFS_SECTOR0 = 8'h00;
    localparam logic [7:0] NECR_OFS_SECTOR1 = 8'h04;
    localparam logic [7:0] NECR_OFS_SECTOR2 = 8'h08;
    localparam logic [7:0] NECR_OFS_SECTOR3 = 8'h0c;
    localparam logic [7:0] NECR_OFS_SECTOR4 = 8'h10;
    localparam logic [7:0] NECR_OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] NECR_OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] NECR_OFS_PAGE_SIZE = 8'h28;
    localparam int NECR_BIT_POS_LSB = 0;
    localparam int NECR_BIT_POS_W = 3;
    localparam int NECR_WORD_LSB = 3;
    localparam int NECR_WORD_W = 8;
    localparam int NECR_PARITY_LSB = 12;
    localparam int NECR_PARITY_W = 11;
    localparam logic [31:0] NECR_RESULT_RESET = 32'h0000_0000;
    localparam logic [4:0] NECR_MASK_RESET = 5'h00;
    localparam logic [1:0] NECR_PAGE_RESET = 2'h0;
    typedef enum logic [1:0] {
        NECR_PAGE_512 = 2'b00,
        NECR_PAGE_2048 = 2'b01,
        NECR_PAGE_4096 = 2'b10
    } necr_page_type;
    typedef enum logic [1:0] {
        NECR_ERR_NONE = 2'b00,
        NECR_ERR_SINGLE = 2'b01,
        NECR_ERR_MULTI = 2'b10,
        NECR_ERR_PARITY = 2'b11
    } necr_err_type;
endpackage

// ### necr_result_if.sv
`timescale 1ns/1ps
interface necr_result_if;
    import necr_pkg::*;
    logic [NECR_SECTORS-1:0] load;
    logic [NECR_SECTORS-1:0] multi;
    logic [NECR_PARITY_W-1:0] parity [NECR_SECTORS];
    logic [NECR_WORD_W-1:0] word_index [NECR_SECTORS];
    logic [NECR_BIT_POS_W-1:0] bit_pos [NECR_SECTORS];
    modport src (output load, multi, parity, word_index, bit_pos);
    modport dst (input load, multi, parity, word_index, bit_pos);
endinterface

// ### necr_result_mem.sv
`timescale 1ns/1ps
module necr_result_mem
    import necr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    necr_result_if.dst res,
    input wire logic [2:0] rd_idx_in,
    output logic [31:0] rd_data_out
);
    logic [31:0] word_r [NECR_SECTORS];
    logic [31:0] word_nxt [NECR_SECTORS];
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;

    // Multi-error sectors keep parity; position fields are cleared as unusable.
    function automatic logic [31:0] pack_word(input int s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[NECR_PARITY_LSB +: NECR_PARITY_W] = res.parity[s];
        if (!res.multi[s]) begin
            w[NECR_WORD_LSB +: NECR_WORD_W] = res.word_index[s];
            w[NECR_BIT_POS_LSB +: NECR_BIT_POS_W] = res.bit_pos[s];
        end
        return w;
    endfunction

    always_comb begin
        for (int s = 0; s < NECR_SECTORS; s++) begin
            word_nxt[s] = res.load[s] ? pack_word(s) : word_r[s];
        end
        rd_nxt = (int'(rd_idx_in) < NECR_SECTORS) ?
            word_r[rd_idx_in] : 32'h0000_0000;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < NECR_SECTORS; s++) begin
                word_r[s] <= NECR_RESULT_RESET;
            end
            rd_r <= 32'h0000_0000;
        end else if (en_in) begin
            word_r <= word_nxt;
            rd_r <= rd_nxt;
        end
    end
    assign rd_data_out = rd_r;
endmodule

// ### necr_sector_regs.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// - One code per 256-byte sector; pages of 512, 2048 or 4096 bytes. Codes are kept for sectors 0 to 4 only, bytes 0 to 1279.
// - Sector register n covers page bytes 256n to 256n+255.
// - On a single error, report the wrong bit within the byte.
// - On a single error, report the index of the faulty byte.
// - With multiple errors, position fields are meaningless and unused.
module necr_sector_regs
    import necr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic [necr_pkg::NECR_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic page_start_in,
    input wire logic [11:0] page_byte_addr_in,
    input wire logic sector_done_in,
    input wire logic [necr_pkg::NECR_PARITY_W-1:0] calc_parity_in,
    input wire logic [1:0] calc_err_in,
    input wire logic [necr_pkg::NECR_WORD_W-1:0] calc_word_in,
    input wire logic [necr_pkg::NECR_BIT_POS_W-1:0] calc_bit_in,
    output logic [1:0] page_size_out,
    output logic [necr_pkg::NECR_SECTORS-1:0] sector_done_out,
    output logic irq_out
);
    import necr_pkg::*;

    necr_result_if res_if ();

    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_n;
    logic [NECR_SECTORS-1:0] status_r;
    logic [NECR_SECTORS-1:0] status_nxt;
    logic [NECR_SECTORS-1:0] mask_r;
    logic [NECR_SECTORS-1:0] mask_nxt;
    logic [1:0] page_r;
    logic [1:0] page_nxt;
    logic [NECR_SECTORS-1:0] done_r;
    logic [NECR_SECTORS-1:0] done_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [2:0] sector_idx;
    logic [NECR_SECTORS-1:0] load_vec;
    logic [31:0] mem_rd;
    logic [31:0] misc_rd_r;
    logic [31:0] misc_rd_nxt;
    logic rd_mem_r;
    logic rd_mem_nxt;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    function automatic logic is_result_addr(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= NECR_OFS_SECTOR4);
    endfunction

    // The sector index is bits 10:8 of the page byte address, the address divided by 256 modulo 8.
    assign sector_idx = page_byte_addr_in[10:8];

    genvar g;
    generate
        for (g = 0; g < NECR_SECTORS; g++) begin : g_sec
            // Sectors past the configured page end never load.
            assign load_vec[g] = sector_done_in && (sector_idx == 3'(g))
                && (page_byte_addr_in[11] == 1'b0)
                && ((page_r != NECR_PAGE_512) || (g < 2));
            assign res_if.load[g] = load_vec[g];
            assign res_if.multi[g] = (calc_err_in == NECR_ERR_MULTI);
            assign res_if.parity[g] = calc_parity_in;
            assign res_if.word_index[g] = calc_word_in;
            assign res_if.bit_pos[g] = calc_bit_in;
        end
    endgenerate

    necr_result_mem u_mem (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .en_in(clk_en_in),
        .res(res_if.dst),
        .rd_idx_in(reg_addr_in[4:2]),
        .rd_data_out(mem_rd)
    );

    always_comb begin
        status_nxt = status_r;
        mask_nxt = mask_r;
        page_nxt = page_r;
        done_nxt = done_r;
        misc_rd_nxt = 32'h0000_0000;
        rd_mem_nxt = 1'b0;
        if (page_start_in) begin
            done_nxt = '0;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                NECR_OFS_IRQ_STATUS: begin
                    status_nxt = status_r & ~reg_wdata_in[NECR_SECTORS-1:0];
                end
                NECR_OFS_IRQ_MASK: begin
                    mask_nxt = reg_wdata_in[NECR_SECTORS-1:0];
                end
                NECR_OFS_PAGE_SIZE: begin
                    if (reg_wdata_in[1:0] != 2'b11) begin
                        page_nxt = reg_wdata_in[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Set wins over a clear in the same cycle.
        status_nxt = status_nxt | load_vec;
        done_nxt = done_nxt | load_vec;
        if (reg_rd_in) begin
            rd_mem_nxt = is_result_addr(reg_addr_in);
            case (reg_addr_in)
                NECR_OFS_IRQ_STATUS: misc_rd_nxt = 32'(status_r);
                NECR_OFS_IRQ_MASK: misc_rd_nxt = 32'(mask_r);
                NECR_OFS_PAGE_SIZE: misc_rd_nxt = 32'(page_r);
                default: misc_rd_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
            mask_r <= NECR_MASK_RESET;
            page_r <= NECR_PAGE_RESET;
            done_r <= '0;
            irq_r <= 1'b0;
            misc_rd_r <= 32'h0000_0000;
            rd_mem_r <= 1'b0;
        end else if (clk_en_in) begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            page_r <= page_nxt;
            done_r <= done_nxt;
            irq_r <= irq_nxt;
            misc_rd_r <= misc_rd_nxt;
            rd_mem_r <= rd_mem_nxt;
        end
    end

    // Read data are combined from two registers so no extra latency appears.
    assign reg_rdata_out = rd_mem_r ? mem_rd : misc_rd_r;
    assign page_size_out = page_r;
    assign sector_done_out = done_r;
    assign irq_out = irq_r;

    // A missed load would leave stale parity for the spare-area copy, so
    // the path from finished sector 0 to its status bit is watched here.
    AST_LOAD_SETS_STATUS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && load_vec[0] |=> status_r[0])
        else $error("sector 0 status not set");

    AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in |=> irq_r == |(status_r & mask_r))
        else $error("irq mismatch");

    AST_RESERVED_ZERO: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) rd_mem_r |-> (mem_rd[31:23] == 9'h0
        && mem_rd[11] == 1'b0)) else $error("reserved bits set");

    AST_BIT_REPORTED: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) load_vec[0] && calc_err_in == NECR_ERR_SINGLE
        && clk_en_in ##1 reg_rd_in && reg_addr_in == NECR_OFS_SECTOR0
        && clk_en_in && !sector_done_in |=> reg_rdata_out[2:0]
        == $past(calc_bit_in, 2)) else $error("bit position lost");

    AST_NO_LOAD_BEYOND: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) page_r == NECR_PAGE_512 |-> load_vec[4:2] == 3'h0)
        else $error("load beyond 512-byte page");

    AST_MULTI_CLEARS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) load_vec[0] && calc_err_in == NECR_ERR_MULTI
        && clk_en_in ##1 reg_rd_in && reg_addr_in == NECR_OFS_SECTOR0
        && clk_en_in |=> reg_rdata_out[10:0] == 11'h0)
        else $error("multi-error positions not cleared");

    AST_WORD_REPORTED: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) load_vec[0] && calc_err_in == NECR_ERR_SINGLE
        && clk_en_in ##1 reg_rd_in && reg_addr_in == NECR_OFS_SECTOR0
        && clk_en_in && !sector_done_in |=> reg_rdata_out[10:3]
        == $past(calc_word_in, 2)) else $error("word index lost");

    AST_PARITY_REPORTED: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) load_vec[0] && clk_en_in
        ##1 reg_rd_in && reg_addr_in == NECR_OFS_SECTOR0
        && clk_en_in && !sector_done_in |=> reg_rdata_out[22:12]
        == $past(calc_parity_in, 2)) else $error("parity lost");

    AST_MASK_WRITE: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_wr_in
        && reg_addr_in == NECR_OFS_IRQ_MASK |=> mask_r
        == $past(reg_wdata_in[4:0])) else $error("mask not written");

    AST_MASK_HOLD: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in
        && !(reg_wr_in && reg_addr_in == NECR_OFS_IRQ_MASK)
        |=> $stable(mask_r)) else $error("mask changed unasked");

    AST_STATUS_CLEAR: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_wr_in
        && reg_addr_in == NECR_OFS_IRQ_STATUS && load_vec == '0
        |=> (status_r & $past(reg_wdata_in[NECR_SECTORS-1:0])) == '0)
        else $error("status bit not cleared");

    // A result arriving with a clear must stay visible, or its event is lost.
    AST_SET_WINS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && load_vec != '0
        |=> (status_r & $past(load_vec)) == $past(load_vec))
        else $error("status set lost");

    AST_STATUS_HOLD: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && !reg_wr_in && load_vec == '0
        |=> $stable(status_r)) else $error("status changed unasked");

    AST_DONE_SETS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && load_vec != '0
        |=> (done_r & $past(load_vec)) == $past(load_vec))
        else $error("sector done not set");

    AST_DONE_STICKY: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && !page_start_in
        |=> (done_r & $past(done_r)) == $past(done_r))
        else $error("sector done dropped");

    AST_PAGE_START_CLEARS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && page_start_in && load_vec == '0
        |=> done_r == '0) else $error("page start did not clear");

    AST_PAGE_WRITE: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_wr_in
        && reg_addr_in == NECR_OFS_PAGE_SIZE && reg_wdata_in[1:0] != 2'b11
        |=> page_r == $past(reg_wdata_in[1:0]))
        else $error("page size not written");

    AST_PAGE_REFUSE: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_wr_in
        && reg_addr_in == NECR_OFS_PAGE_SIZE && reg_wdata_in[1:0] == 2'b11
        |=> $stable(page_r)) else $error("unsupported page size taken");

    AST_PAGE_HOLD: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && !reg_wr_in |=> $stable(page_r))
        else $error("page size changed unasked");

    // With the enable low nothing may move, so a result offered while stalled is dropped.
    AST_FREEZE: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) !clk_en_in |=> $stable(status_r)
        && $stable(mask_r) && $stable(page_r) && $stable(done_r)
        && $stable(irq_r)) else $error("state moved while frozen");

    AST_RD_STATUS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_rd_in
        && reg_addr_in == NECR_OFS_IRQ_STATUS
        |=> reg_rdata_out == 32'($past(status_r)))
        else $error("status read wrong");

    AST_RD_MASK: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_rd_in
        && reg_addr_in == NECR_OFS_IRQ_MASK
        |=> reg_rdata_out == 32'($past(mask_r)))
        else $error("mask read wrong");

    AST_RD_PAGE: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_rd_in
        && reg_addr_in == NECR_OFS_PAGE_SIZE
        |=> reg_rdata_out == 32'($past(page_r)))
        else $error("page size read wrong");

    AST_RD_UNMAPPED: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && reg_rd_in
        && reg_addr_in > NECR_OFS_PAGE_SIZE
        |=> reg_rdata_out == 32'h0000_0000) else $error("unmapped read");

    AST_RD_IDLE: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) clk_en_in && !reg_rd_in
        |=> reg_rdata_out == 32'h0000_0000) else $error("read data left");

    AST_NO_LOAD_HIGH: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n) page_byte_addr_in[11] |-> load_vec == '0)
        else $error("load past byte 2047");

    AST_RESET_STAGES: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) !rst_s1_r |=> !rst_n)
        else $error("reset released early");

    // Each of sectors 0 to 4 that the page holds must take its own result.
    generate
        for (g = 0; g < NECR_SECTORS; g++) begin : g_chk
            AST_SECTOR_LOAD: assert property (@(posedge ref_clk_in)
                disable iff (!rst_n) clk_en_in && sector_done_in
                && page_byte_addr_in[11:8] == 4'(g)
                && (page_r != NECR_PAGE_512 || g < 2)
                |=> status_r[g] && done_r[g])
                else $error("sector result not taken");
        end
    endgenerate
endmodule

// ### necr_calc_model.sv
`timescale 1ns/1ps
// Stands in for the parity engine that watches page data on the memory bus.
module necr_calc_model (
    input wire logic clk_in,
    output logic page_start_out,
    output logic [11:0] byte_addr_out,
    output logic done_out,
    output logic [10:0] parity_out,
    output logic [1:0] err_out,
    output logic [7:0] word_out,
    output logic [2:0] bit_out
);
    initial begin
        page_start_out = 1'b0;
        done_out = 1'b0;
        {byte_addr_out, parity_out, err_out, word_out, bit_out} = '1;
    end
    task automatic new_page();
        @(posedge clk_in) page_start_out <= 1'b1;
        @(posedge clk_in) page_start_out <= 1'b0;
    endtask
    // One result per 256-byte sector, offered with a one-cycle pulse.
    task automatic finish(input logic [11:0] a, input logic [10:0] p,
                          input logic [1:0] e, input logic [7:0] w,
                          input logic [2:0] b);
        @(posedge clk_in);
        {byte_addr_out, parity_out, err_out, word_out, bit_out} <=
            {a, p, e, w, b};
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
        // Stale qualifiers must not look valid once the pulse is gone.
        {byte_addr_out, parity_out, err_out, word_out, bit_out} <=
            ~{a, p, e, w, b};
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    import necr_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cen = 1'b1;
    logic [31:0] rdata;
    logic pstart, sdone, irq;
    logic [11:0] baddr;
    logic [10:0] par;
    logic [1:0] err, psize;
    logic [7:0] word;
    logic [2:0] bitp;
    logic [4:0] done_bits;
    logic [31:0] spare [5];
    logic [31:0] d;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    necr_calc_model necr_calc_model_inst (.clk_in(clk),
        .page_start_out(pstart), .byte_addr_out(baddr), .done_out(sdone),
        .parity_out(par), .err_out(err), .word_out(word), .bit_out(bitp));
    necr_sector_regs necr_sector_regs_inst (.ref_clk_in(clk),
        .rstn_in(rstn), .clk_en_in(cen), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .page_start_in(pstart),
        .page_byte_addr_in(baddr), .sector_done_in(sdone),
        .calc_parity_in(par), .calc_err_in(err), .calc_word_in(word),
        .calc_bit_in(bitp), .page_size_out(psize),
        .sector_done_out(done_bits), .irq_out(irq));
    task automatic test_done();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            $display("unexpected at %0t: run did not finish", $time);
            test_done();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [31:0] res(input int n, input bit multi);
        logic [10:0] p;
        p = 11'h7f0 + 11'(n);
        return multi ? {9'h0, p, 12'h0} : {9'h0, p, 1'b0, 8'hf0 + 8'(n),
            3'(n + 3)};
    endfunction
    task automatic t_results();
        wr_reg(NECR_OFS_PAGE_SIZE, 32'h1);
        for (int n = 0; n < 5; n++) begin
            necr_calc_model_inst.finish(12'(256 * n + 255), 11'h7f0 + 11'(n),
                2'h1, 8'hf0 + 8'(n), 3'(n + 3));
        end
        necr_calc_model_inst.finish(12'h100, 11'h7f1, 2'h2, 8'h55, 3'h5);
        wr_reg(NECR_OFS_SECTOR0, 32'hffff_ffff);
        for (int n = 0; n < 5; n++) begin
            rd_reg(8'(4 * n), spare[n]);
            check(spare[n], res(n, n == 1));
        end
        check({27'h0, done_bits}, 32'h1f);
        check({30'h0, psize}, 32'h1);
    endtask
    task automatic t_irq();
        check({31'h0, irq}, 32'h0);
        rd_reg(NECR_OFS_IRQ_STATUS, d);
        check(d, 32'h1f);
        wr_reg(NECR_OFS_IRQ_MASK, 32'h1f);
        @(posedge clk) #1 check({31'h0, irq}, 32'h1);
        wr_reg(NECR_OFS_IRQ_STATUS, 32'h1f);
        @(posedge clk) #1 check({31'h0, irq}, 32'h0);
        rd_reg(8'h40, d);
        check(d, 32'h0);
    endtask
    task automatic t_page_limits();
        necr_calc_model_inst.new_page();
        #1 check({27'h0, done_bits}, 32'h0);
        wr_reg(NECR_OFS_PAGE_SIZE, 32'h0);
        wr_reg(NECR_OFS_PAGE_SIZE, 32'h3);
        rd_reg(NECR_OFS_PAGE_SIZE, d);
        check(d, 32'h0);
        // A 512-byte page has only sectors 0 and 1.
        necr_calc_model_inst.finish(12'h300, 11'h123, 2'h1, 8'h12, 3'h1);
        wr_reg(NECR_OFS_PAGE_SIZE, 32'h2);
        necr_calc_model_inst.finish(12'h800, 11'h321, 2'h1, 8'h21, 3'h2);
        @(posedge clk) #1 check({27'h0, done_bits}, 32'h0);
        rd_reg(NECR_OFS_SECTOR3, d);
        check(d, res(3, 0));
    endtask
    task automatic t_freeze();
        @(posedge clk) cen <= 1'b0;
        necr_calc_model_inst.finish(12'h0ff, 11'h001, 2'h1, 8'h01, 3'h1);
        wr_reg(NECR_OFS_IRQ_MASK, 32'h0);
        @(posedge clk) cen <= 1'b1;
        rd_reg(NECR_OFS_IRQ_MASK, d);
        check(d, 32'h1f);
        check({27'h0, done_bits}, 32'h0);
        rd_reg(NECR_OFS_SECTOR0, d);
        check(d, res(0, 0));
    endtask
    // The read is sampled on the edge right after the load edge.
    task automatic t_load_read(input logic [1:0] e, input logic [10:0] p,
                               input logic [7:0] w, input logic [2:0] b,
                               input logic [31:0] exp);
        fork
            necr_calc_model_inst.finish(12'h0ff, p, e, w, b);
            begin
                @(posedge clk);
                rd_reg(NECR_OFS_SECTOR0, d);
            end
        join
        check(d, exp);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(NECR_OFS_SECTOR4, d);
        check(d, NECR_RESULT_RESET);
        t_results();
        t_irq();
        t_page_limits();
        t_freeze();
        t_load_read(2'h2, 11'h155, 8'h3c, 3'h6, 32'h0015_5000);
        t_load_read(2'h1, 11'h2aa, 8'hc3, 3'h5, 32'h002a_a61d);
        check({31'h0, irq}, 32'h1);
        test_done();
    end
endmodule
